// ---- rtl/phymp_port.sv ----
// Purpose: MAC-side data port, strap capture and LEDs of a 10/100 PHY
// Assumes: core_clk 20 MHz; ref clock far slower, sampled as data
// Notes:   FIFO and top live here; APB slave answers with one wait
//
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "phymp_map.svh"

// ==========================================================
// Small synchronous FIFO
module phymp_fifo #(
  parameter int WIDTH = `PHYMP_FIFO_WIDTH,
  parameter int DEPTH = `PHYMP_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wrPtr_q;
  logic [AW-1:0] rdPtr_q;
  logic [AW:0] count_q;
  wire push = inValid & inReady;
  wire pop = outValid & outReady;

  assign inReady = (count_q != (AW+1)'(DEPTH));
  assign outValid = (count_q != '0);
  assign outData = mem_q[rdPtr_q];

  function automatic logic [AW-1:0] nextPtr(input logic [AW-1:0] p);
    nextPtr = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : nextPtr

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) wrPtr_q <= nextPtr(wrPtr_q);
      if (pop) rdPtr_q <= nextPtr(rdPtr_q);
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Storage needs no reset; validity comes from count_q
  always_ff @(posedge core_clk) begin
    if (push) mem_q[wrPtr_q] <= inData;
  end
endmodule : phymp_fifo

// ==========================================================
// Top
module phymp_port (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Reference clock from the board
  input wire logic refClk,
  // Shared strap/output pins
  input wire phymp_pkg::phymp_pins_t pinIn,
  output phymp_pkg::phymp_pins_t pinOut,
  output phymp_pkg::phymp_pins_t pinOe,
  output logic ledOutThree,
  // Transmit inputs from the MAC
  input wire logic txEn,
  input wire logic [3:0] txd,
  // Strap results
  output logic [4:0] mgmtAddr,
  output logic fullRegAccess,
  // APB
  input wire phymp_pkg::phymp_apb_req_t apbReq,
  output phymp_pkg::phymp_apb_rsp_t apbRsp
);
  import phymp_pkg::*;

  // ==========================================================
  // Input synchronisers
  logic [2:0] refSync_q;
  phymp_pins_t pinMeta_q;
  phymp_pins_t pinSync_q;
  logic [4:0] txMeta_q;
  logic [4:0] txSync_q;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      refSync_q <= '0;
      pinMeta_q <= '0;
      pinSync_q <= '0;
      txMeta_q <= '0;
      txSync_q <= '0;
    end else begin
      refSync_q <= {refSync_q[1:0], refClk};
      pinMeta_q <= pinIn;
      pinSync_q <= pinMeta_q;
      txMeta_q <= {txEn, txd};
      txSync_q <= txMeta_q;
    end
  end

  wire refRise = refSync_q[1] & ~refSync_q[2];
  wire refFall = ~refSync_q[1] & refSync_q[2];

  // ==========================================================
  // Strap capture, once after reset release
  phymp_strap_st_t strapSt_q;
  logic [1:0] strapCnt_q;
  phymp_pins_t strap_q;
  wire strapTake = (strapSt_q == STRAP_SYNC) &&
    (strapCnt_q == `PHYMP_STRAP_WAIT);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      strapSt_q <= STRAP_SYNC;
      strapCnt_q <= '0;
    end else begin
      case (strapSt_q)
        STRAP_SYNC: begin
          strapCnt_q <= strapCnt_q + 2'h1;
          if (strapTake) strapSt_q <= STRAP_RUN;
        end
        STRAP_RUN: strapSt_q <= STRAP_RUN;
        default: strapSt_q <= STRAP_SYNC;
      endcase
    end
  end

  // Sampled once, after the pins pass both synchroniser stages
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      strap_q <= '0;
    end else if (strapTake) begin
      strap_q <= pinSync_q;
    end
  end

  wire strapsValid = (strapSt_q == STRAP_RUN);
  wire [4:0] addrD = {strap_q.addr4, strap_q.addr3, strap_q.addr2,
    strap_q.addr1, strap_q.addr0};
  wire phymp_mode_t mode = strap_q.rmiiSel ? MODE_RMII :
    (strap_q.siSel ? MODE_SI : MODE_MII);
  wire isMii = strapsValid && (mode == MODE_MII);
  wire isRmii = strapsValid && (mode == MODE_RMII);

  // ==========================================================
  // Control register and derived speed/duplex
  logic [5:0] ctrl_q;
  wire speed100 = strap_q.autoneg ? ctrl_q[`PHYMP_CTRL_SPEED] :
    strap_q.speed;
  wire fullDuplex = strap_q.autoneg ? ctrl_q[`PHYMP_CTRL_DUPLEX] :
    strap_q.duplex;
  // Isolation input only exists when strapped on; pin is synchronised but ignored else
  wire isoActive = strap_q.rxIsolate & pinSync_q.addr1;

  // ==========================================================
  // Transmit capture into the FIFO
  logic [1:0] txLow_q;
  logic txHalf_q;
  logic txOvf_q;
  wire fifoInReady;
  wire fifoOutValid;
  wire [3:0] fifoOutData;
  wire miiPush = isMii & refRise & txSync_q[4];
  wire rmiiPush = isRmii & refRise & txSync_q[4] & txHalf_q;
  wire txPush = miiPush | rmiiPush;
  wire [3:0] txNibble = isRmii ? {txSync_q[1:0], txLow_q} :
    txSync_q[3:0];

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      txLow_q <= '0;
      txHalf_q <= 1'b0;
    end else if (isRmii & refRise) begin
      // Low dibit first; a frame end drops an odd dibit
      txLow_q <= txSync_q[1:0];
      txHalf_q <= txSync_q[4] & ~txHalf_q;
    end
  end

  // ==========================================================
  // APB decode
  wire apbAccess = apbReq.psel & apbReq.penable;
  wire apbCommit = apbAccess & apbRsp.pready;
  wire hitCtrl = (apbReq.paddr == `PHYMP_OFS_CTRL);
  wire hitStrap = (apbReq.paddr == `PHYMP_OFS_STRAP);
  wire hitTx = (apbReq.paddr == `PHYMP_OFS_TXDATA);
  wire hitRx = (apbReq.paddr == `PHYMP_OFS_RXDATA);
  wire hitStat = (apbReq.paddr == `PHYMP_OFS_STATUS);
  wire hitAny = hitCtrl | hitStrap | hitTx | hitRx | hitStat;
  wire wrCommit = apbCommit & apbReq.pwrite;
  wire txPop = apbCommit & ~apbReq.pwrite & hitTx;
  logic rxPend_q;
  logic [3:0] rxNib_q;
  wire rxLoad = wrCommit & hitRx & ~rxPend_q;
  wire ovfClr = wrCommit & hitStat & apbReq.pwdata[`PHYMP_ST_OVF];

  phymp_fifo #(
    .WIDTH(`PHYMP_FIFO_WIDTH),
    .DEPTH(`PHYMP_FIFO_DEPTH)
  ) uTxFifo (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .inValid(txPush),
    .inReady(fifoInReady),
    .inData(txNibble),
    .outValid(fifoOutValid),
    .outReady(txPop),
    .outData(fifoOutData)
  );

  wire [31:0] statusWord = {27'h0, fullDuplex, speed100, isoActive,
    rxPend_q, txOvf_q};
  wire [31:0] strapWord = {14'h0, 2'(mode), 1'b0, strap_q};
  // Empty reads show a zero nibble rather than a stale slot
  wire [31:0] txWord = {23'h0, fifoOutValid, 4'h0,
    fifoOutValid ? fifoOutData : 4'h0};
  wire [31:0] rdWord = hitCtrl ? {26'h0, ctrl_q} :
    hitStrap ? strapWord :
    hitTx ? txWord :
    hitRx ? {27'h0, rxPend_q, rxNib_q} :
    hitStat ? statusWord : 32'h0;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      apbRsp <= '0;
      ctrl_q <= `PHYMP_CTRL_RST;
      txOvf_q <= 1'b0;
    end else begin
      // One wait state lets the answer come from a flop
      apbRsp.pready <= apbAccess & ~apbRsp.pready;
      apbRsp.pslverr <= apbAccess & ~apbRsp.pready & ~hitAny;
      apbRsp.prdata <= apbReq.pwrite ? 32'h0 : rdWord;
      if (wrCommit & hitCtrl) ctrl_q <= apbReq.pwdata[5:0];
      // Overflow seen in the clear cycle survives the clear
      txOvf_q <= (txOvf_q & ~ovfClr) | (txPush & ~fifoInReady);
    end
  end

  // ==========================================================
  // Receive path: software nibble out, dibits in RMII mode
  logic rxHalf_q;
  logic [3:0] rxd_q;
  logic rxdv_q;
  wire rxOk = rxPend_q & ~isoActive;
  wire rxStep = refFall & (isMii | isRmii);
  wire rxDone = rxStep & rxOk & (isMii | rxHalf_q);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rxPend_q <= 1'b0;
      rxNib_q <= '0;
      rxHalf_q <= 1'b0;
      rxd_q <= '0;
      rxdv_q <= 1'b0;
    end else begin
      if (rxLoad) begin
        rxPend_q <= 1'b1;
        rxNib_q <= apbReq.pwdata[3:0];
      end else if (rxDone) begin
        rxPend_q <= 1'b0;
      end
      // Isolation blanks the outputs at once, not at the next ref edge
      if (rxStep | isoActive) begin
        if (!rxOk) begin
          rxd_q <= '0;
          rxdv_q <= 1'b0;
          rxHalf_q <= 1'b0;
        end else if (isMii) begin
          rxd_q <= rxNib_q;
          rxdv_q <= 1'b1;
        end else begin
          rxd_q <= {2'h0, rxHalf_q ? rxNib_q[3:2] : rxNib_q[1:0]};
          rxdv_q <= 1'b1;
          rxHalf_q <= ~rxHalf_q;
        end
      end
    end
  end

  // ==========================================================
  // LEDs and pin drive
  function automatic logic ledFn(input logic [1:0] sel, input logic dflt,
      input logic alt);
    case (sel)
      `PHYMP_LED_DEFAULT: ledFn = dflt;
      `PHYMP_LED_OFF: ledFn = 1'b0;
      `PHYMP_LED_ON: ledFn = 1'b1;
      default: ledFn = alt;
    endcase
  endfunction : ledFn

  wire activity = txSync_q[4] | rxdv_q;
  wire led0 = ledFn(ctrl_q[`PHYMP_CTRL_LED0_LO +: 2], activity,
    fullDuplex);
  wire led1 = ledFn(ctrl_q[`PHYMP_CTRL_LED1_LO +: 2], speed100,
    fullDuplex);
  // Clock out is the delayed ref so it lines up with rxd_q updates
  wire clkOut = refSync_q[2];
  phymp_pins_t outD;
  phymp_pins_t oeD;

  always_comb begin
    outD = '0;
    oeD = '0;
    if (strapsValid) begin
      outD.addr0 = led0;
      oeD.addr0 = 1'b1;
      outD.addr1 = led1;
      oeD.addr1 = ~strap_q.rxIsolate;
      outD.addr2 = 1'b1;
      oeD.addr2 = 1'b1;
      outD.addr4 = fullDuplex;
      oeD.addr4 = 1'b1;
      oeD.siSel = 1'b1;
      outD.rxIsolate = rxd_q[1];
      oeD.rxIsolate = isMii | isRmii;
      outD.duplex = rxd_q[0];
      oeD.duplex = isMii | isRmii;
      outD.rmiiSel = rxdv_q;
      oeD.rmiiSel = isMii | isRmii;
      outD.addr3 = rxd_q[2];
      oeD.addr3 = isMii;
      outD.autoCrossover = rxd_q[3];
      oeD.autoCrossover = isMii;
      outD.autoneg = clkOut;
      oeD.autoneg = isMii;
      outD.speed = clkOut;
      oeD.speed = isMii;
      outD.hw_sw_control_strap = rxdv_q;
      oeD.hw_sw_control_strap = isMii;
      oeD.nodeRepeater = isMii;
      oeD.regAccess = isMii;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pinOut <= '0;
      pinOe <= '0;
      ledOutThree <= 1'b0;
      mgmtAddr <= '0;
      fullRegAccess <= 1'b0;
    end else begin
      pinOut <= outD;
      pinOe <= oeD;
      ledOutThree <= strapsValid & isoActive;
      mgmtAddr <= addrD;
      fullRegAccess <= strap_q.regAccess;
    end
  end

endmodule : phymp_port

// ---- pkg/phymp_map.svh ----
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: APB byte addresses, 32-bit words
// Notes:   Definitions only
`ifndef PHYMP_MAP_SVH
`define PHYMP_MAP_SVH

// ==========================================================
// Register byte offsets
`define PHYMP_OFS_CTRL 8'h00
`define PHYMP_OFS_STRAP 8'h04
`define PHYMP_OFS_TXDATA 8'h08
`define PHYMP_OFS_RXDATA 8'h0C
`define PHYMP_OFS_STATUS 8'h10

// ==========================================================
// Control fields
`define PHYMP_CTRL_LED0_LO 0
`define PHYMP_CTRL_LED1_LO 2
`define PHYMP_CTRL_SPEED 4
`define PHYMP_CTRL_DUPLEX 5
`define PHYMP_CTRL_RST 6'h00

// ==========================================================
// Status and data fields
`define PHYMP_ST_OVF 0
`define PHYMP_ST_RXPEND 1
`define PHYMP_ST_ISO 2
`define PHYMP_ST_SPD 3
`define PHYMP_ST_FDX 4
`define PHYMP_DATA_VALID 8
`define PHYMP_STRAP_MODE_LO 16

// ==========================================================
// LED function selects
`define PHYMP_LED_DEFAULT 2'h0
`define PHYMP_LED_OFF 2'h1
`define PHYMP_LED_ON 2'h2
`define PHYMP_LED_ALT 2'h3

// ==========================================================
// Timing and FIFO size
`define PHYMP_CLK_NS 50
`define PHYMP_STRAP_WAIT 2'h2
`define PHYMP_FIFO_DEPTH 4
`define PHYMP_FIFO_WIDTH 4

`endif

// ---- pkg/phymp_pkg.sv ----
// Purpose: Types shared by the MAC-port and strap logic
// Assumes: phymp_map.svh holds all numbers
// Notes:   Pin bundle carries one bit per shared strap pin
package phymp_pkg;

  // ==========================================================
  // Shared strap/output pins, one bit each
  typedef struct packed {
    logic autoCrossover;
    logic hw_sw_control_strap;
    logic regAccess;
    logic nodeRepeater;
    logic autoneg;
    logic speed;
    logic rmiiSel;
    logic siSel;
    logic duplex;
    logic rxIsolate;
    logic addr4;
    logic addr3;
    logic addr2;
    logic addr1;
    logic addr0;
  } phymp_pins_t;

  // ==========================================================
  // APB request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } phymp_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } phymp_apb_rsp_t;

  typedef enum logic [1:0] {
    MODE_MII,
    MODE_SI,
    MODE_RMII
  } phymp_mode_t;

  typedef enum logic [1:0] {
    STRAP_SYNC,
    STRAP_RUN
  } phymp_strap_st_t;

endpackage : phymp_pkg

// ---- dv/phymp_port_properties.sv ----
// Purpose: Port-level properties of the MAC port and strap logic
// Assumes: Straps steady from reset through the first edges after it
// Notes:   Straps are re-latched here from the pins, not from the core
`timescale 1ns/1ps
module phymp_port_checker (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Observed ports
  input wire phymp_pkg::phymp_pins_t pinIn,
  input wire phymp_pkg::phymp_pins_t pinOut,
  input wire phymp_pkg::phymp_pins_t pinOe,
  input wire logic ledOutThree,
  input wire logic [4:0] mgmtAddr,
  input wire logic fullRegAccess,
  input wire phymp_pkg::phymp_apb_rsp_t apbRsp
);
  import phymp_pkg::*;
  logic [2:0] relCnt_q;
  phymp_pins_t strap_q;
  wire settled = (relCnt_q == 3'h7);
  wire miiMode = !strap_q.rmiiSel && !strap_q.siSel;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // ==========================================================
  // Edges since release; saturates so late checks stay armed
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      relCnt_q <= 3'h0;
    end else if (relCnt_q != 3'h7) begin
      relCnt_q <= relCnt_q + 3'h1;
    end
  end
  always_ff @(posedge core_clk) begin
    if (rst_b && relCnt_q == 3'h0) begin
      strap_q <= pinIn;
    end
  end
  // ==========================================================
  // Properties
  a_oe_quiet: assert property (relCnt_q < 3'h3 |-> pinOe == '0)
    else $error("pin drivers on before straps taken");
  a_straps_hold: assert property (settled |-> $stable(mgmtAddr)
    && $stable(fullRegAccess)) else $error("strap results moved");
  a_addr_strap: assert property (settled |-> mgmtAddr ==
    {strap_q.addr4, strap_q.addr3, strap_q.addr2, strap_q.addr1,
    strap_q.addr0}) else $error("address differs from straps");
  a_reg_access: assert property (settled |->
    fullRegAccess == strap_q.regAccess) else $error("access strap lost");
  a_iso_pin: assert property (settled |->
    pinOe.addr1 == !strap_q.rxIsolate) else $error("LED1 pin role wrong");
  a_txclk_pin: assert property (settled |->
    pinOe.speed == miiMode && pinOe.autoneg == miiMode)
    else $error("clock pins not matching mode");
  a_rx_quiet: assert property (ledOutThree && $past(ledOutThree, 2)
    |-> !pinOut.rmiiSel) else $error("receive valid while isolated");
  a_rxdv_hold: assert property ($rose(pinOut.rmiiSel) |=>
    pinOut.rmiiSel [*6]) else $error("receive valid too short");
  c_iso: cover property (ledOutThree);
  c_rxdv: cover property ($rose(pinOut.rmiiSel));
  c_slverr: cover property (apbRsp.pready && apbRsp.pslverr);
endmodule : phymp_port_checker

bind phymp_port phymp_port_checker u_chk (
  .core_clk(core_clk), .rst_b(rst_b), .pinIn(pinIn), .pinOut(pinOut),
  .pinOe(pinOe), .ledOutThree(ledOutThree), .mgmtAddr(mgmtAddr),
  .fullRegAccess(fullRegAccess), .apbRsp(apbRsp)
);

// ---- dv/phymp_mac_model.sv ----
// Purpose: Behavioural MAC on the far side of the data port
// Assumes: refClk far slower than core_clk
// Notes:   Idle data lines toggle so stale values never look valid
`timescale 1ns/1ps
module phymp_mac_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Board reference and device pins
  input wire logic refClk,
  input wire phymp_pkg::phymp_pins_t pinOut,
  // Bench control
  input wire logic go,
  input wire logic rmii,
  input wire logic [3:0] nib,
  // Transmit lines
  output logic txEn,
  output logic [3:0] txd,
  // Progress and received data
  output logic [7:0] beats,
  output logic [3:0] rxNib,
  output logic [7:0] rxCount
);
  import phymp_pkg::*;
  logic [2:0] refSync;
  logic half;
  wire refRise = refSync[1] && !refSync[2];
  wire refFall = !refSync[1] && refSync[2];
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      refSync <= 3'h0;
      txEn <= 1'b0;
      txd <= 4'h0;
      half <= 1'b0;
      beats <= 8'h00;
      rxNib <= 4'h0;
      rxCount <= 8'h00;
    end else begin
      refSync <= {refSync[1:0], refClk};
      // Change mid-period so the device samples a settled value
      if (refFall && go) begin
        txEn <= 1'b1;
        txd <= rmii ? {~txd[3:2], half ? nib[3:2] : nib[1:0]} : nib;
        half <= rmii && !half;
        beats <= beats + 8'h01;
      end else if (refFall) begin
        txEn <= 1'b0;
        txd <= ~txd;
        half <= 1'b0;
      end
      if (refRise && pinOut.rmiiSel) begin
        rxCount <= rxCount + 8'h01;
        rxNib <= rmii ? {pinOut.rxIsolate, pinOut.duplex, rxNib[3:2]} :
          {pinOut.autoCrossover, pinOut.addr3, pinOut.rxIsolate,
          pinOut.duplex};
      end
    end
  end
endmodule : phymp_mac_model

// ---- dv/testbench.sv ----
// Purpose: Register-level bench for the MAC port and strap logic
// Assumes: APB slave adds one wait; reference slowed to 400 ns
// Notes:   Second strap set is applied by a mid-run reset
`timescale 1ns/1ps
`include "phymp_map.svh"
module testbench;
  import phymp_pkg::*;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic refClk = 1'b0;
  logic go = 1'b0;
  logic rmii = 1'b0;
  logic [3:0] nib = 4'h0;
  logic txEn, fullRegAccess, ledOutThree, e;
  logic [3:0] txd, rxNib;
  logic [7:0] beats, rxCount, c;
  logic [4:0] mgmtAddr;
  logic [31:0] d;
  int mismatches = 0;
  int comparisons = 0;
  phymp_pins_t ext = 15'h5215;
  phymp_pins_t s, pinIn, pinOut, pinOe;
  logic [4:0] sAddr;
  phymp_apb_req_t req = '0;
  phymp_apb_rsp_t apbRsp;
  assign pinIn = phymp_pins_t'((pinOe & pinOut) | (~pinOe & ext));
  assign sAddr = {s.addr4, s.addr3, s.addr2, s.addr1, s.addr0};
  always #25 core_clk = ~core_clk;
  // Slow stand-in for the board reference, phase unrelated
  initial begin
    #73;
    forever #200 refClk = ~refClk;
  end
  phymp_port dut (.core_clk(core_clk), .rst_b(rst_b), .refClk(refClk),
    .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .txEn(txEn),
    .ledOutThree(ledOutThree), .txd(txd), .mgmtAddr(mgmtAddr),
    .fullRegAccess(fullRegAccess), .apbReq(req), .apbRsp(apbRsp));
  phymp_mac_model u_mac (.core_clk(core_clk), .rst_b(rst_b),
    .refClk(refClk), .pinOut(pinOut), .go(go), .rmii(rmii), .nib(nib),
    .txEn(txEn), .txd(txd), .beats(beats), .rxNib(rxNib),
    .rxCount(rxCount));
  // ==========================================================
  // Tasks
  task automatic close_out();
    $display("checks %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out
  task automatic chk(input string what, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] v);
    int i;
    @(posedge core_clk);
    req <= '{1'b1, 1'b0, w, a, v};
    @(posedge core_clk);
    req.penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge core_clk);
      if (apbRsp.pready === 1'b1) break;
    end
    if (i == 20) begin
      mismatches++;
      close_out();
    end
    d = apbRsp.prdata;
    e = apbRsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb
  task automatic wait_on(input logic [7:0] base, n, input logic rx);
    int i;
    for (i = 0; i < 200; i++) begin
      @(posedge core_clk);
      if ((rx ? rxCount : beats) - base == n) break;
    end
    if (i == 200) begin
      mismatches++;
      close_out();
    end
  endtask : wait_on
  task automatic send(input logic [3:0] v, input logic [7:0] per);
    nib <= v;
    go <= 1'b1;
    wait_on(beats, per, 1'b0);
  endtask : send
  task automatic restart(input phymp_pins_t v, input logic m);
    rst_b <= 1'b0;
    ext <= v;
    rmii <= m;
    s = v;
    repeat (5) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge core_clk);
  endtask : restart
  // ==========================================================
  // Sequence
  initial begin
    restart(15'h5215, 1'b0);
    chk("addr", mgmtAddr, sAddr);
    chk("regacc", fullRegAccess, s.regAccess);
    apb(1'b0, `PHYMP_OFS_STRAP, 32'h0);
    chk("strap", d, {14'h0000, 2'h0, 1'h0, s});
    chk("led1", pinOut.addr1, s.speed);
    apb(1'b1, `PHYMP_OFS_CTRL, 32'h0000_0022);
    apb(1'b0, `PHYMP_OFS_STATUS, 32'h0);
    chk("status", d[4:2], {s.duplex, s.speed, 1'b0});
    chk("led0", pinOut.addr0, 1'b1);
    apb(1'b1, `PHYMP_OFS_CTRL, 32'h0000_0005);
    apb(1'b0, `PHYMP_OFS_CTRL, 32'h0);
    chk("ledoff", {d[29:0], pinOut.addr1, pinOut.addr0}, 32'h14);
    ext <= phymp_pins_t'(~s);
    repeat (10) @(posedge core_clk);
    chk("hold", mgmtAddr, sAddr);
    ext <= s;
    for (int i = 0; i < 5; i++) send(4'h3 + 4'(i * 5), 8'h01);
    go <= 1'b0;
    repeat (40) @(posedge core_clk);
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, `PHYMP_OFS_TXDATA, 32'h0);
      chk("tx", d[8:0], i < 4 ? {5'h10, 4'h3 + 4'(i * 5)} : 9'h000);
    end
    apb(1'b0, `PHYMP_OFS_STATUS, 32'h0);
    chk("ovf", d[0], 1'b1);
    apb(1'b1, `PHYMP_OFS_STATUS, 32'h1);
    apb(1'b0, `PHYMP_OFS_STATUS, 32'h0);
    chk("ovfclr", d[0], 1'b0);
    apb(1'b1, `PHYMP_OFS_RXDATA, 32'hA);
    wait_on(rxCount, 8'h01, 1'b1);
    chk("rxmii", rxNib, 4'hA);
    apb(1'b0, 8'h14, 32'h0);
    chk("slverr", e, 1'b1);
    chk("unmapped", d, 32'h0);
    restart(15'h2DAA, 1'b1);
    apb(1'b0, `PHYMP_OFS_STRAP, 32'h0);
    chk("strapb", d, {14'h0000, 2'h2, 1'h0, s});
    chk("isopin", {pinOe.addr1, ledOutThree}, 2'h1);
    apb(1'b1, `PHYMP_OFS_CTRL, 32'h0000_0030);
    apb(1'b0, `PHYMP_OFS_STATUS, 32'h0);
    chk("anstat", d[4:2], 3'h7);
    c = rxCount;
    apb(1'b1, `PHYMP_OFS_RXDATA, 32'h5);
    repeat (40) @(posedge core_clk);
    chk("rxiso", rxCount, c);
    ext.addr1 <= 1'b0;
    repeat (10) @(posedge core_clk);
    apb(1'b1, `PHYMP_OFS_RXDATA, 32'h5);
    wait_on(c, 8'h02, 1'b1);
    chk("rxrmii", rxNib, 4'h5);
    // Several strap pins float in RMII mode, so flipping them bites here
    ext <= phymp_pins_t'(~s);
    repeat (10) @(posedge core_clk);
    chk("holdb", mgmtAddr, sAddr);
    chk("holdr", fullRegAccess, s.regAccess);
    send(4'h6, 8'h02);
    send(4'h9, 8'h02);
    go <= 1'b0;
    repeat (40) @(posedge core_clk);
    apb(1'b0, `PHYMP_OFS_TXDATA, 32'h0);
    chk("txr0", d[8:0], {5'h10, 4'h6});
    apb(1'b0, `PHYMP_OFS_TXDATA, 32'h0);
    chk("txr1", d[8:0], {5'h10, 4'h9});
    close_out();
  end
endmodule : testbench
